/* File: dirc_pkg.sv */
// Package: register map, field layout, reset values and timing for dirc
package dirc_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_ADDR_SEL = 8'h00;
  localparam logic [7:0] OFS_RST_CTL  = 8'h01;
  localparam logic [7:0] OFS_OUT_CFG  = 8'h02;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned ADDR_SRC_BIT   = 0;
  localparam int unsigned ADDR_MSB       = 7;
  localparam int unsigned ADDR_LSB       = 1;
  localparam int unsigned CORE_RST_BIT   = 0;
  localparam int unsigned FULL_RST_BIT   = 1;
  localparam int unsigned OE_VAL_BIT     = 7;
  localparam int unsigned OE_OVR_BIT     = 6;
  localparam int unsigned OSC_EMIT_BIT   = 5;
  localparam int unsigned SLEEP_SEL_BIT  = 4;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_CTL_RST   = 8'h04;
  localparam logic [7:0] OUT_CFG_RST   = 8'h80;
  localparam logic       ADDR_SRC_RST  = 1'h0;
  localparam logic [7:0] RD_UNMAPPED   = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned CORE_RST_NS   = 100;
  localparam logic [4:0]  CORE_RST_CYC  =
    5'((CORE_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dirc_req_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_A, ST_PTR, ST_ACK_D, ST_WR, ST_RD, ST_MACK
  } dirc_state_t;

endpackage

/* File: dirc_i2c_slave.sv */
// Control-bus serial slave that feeds register writes and reads
`timescale 1ns/1ps
module dirc_i2c_slave import dirc_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl,
  input  wire logic       sda_in,
  input  wire logic [6:0] slave_addr,
  input  wire logic [7:0] rd_data,
  output logic            sda_out,
  output logic            sda_oe,
  output logic [7:0]      rd_addr,
  output dirc_req_t       req
);

  dirc_state_t state_ff;
  dirc_state_t nxt_state;
  logic [3:0]  cnt_ff;
  logic [3:0]  nxt_cnt;
  logic [7:0]  sh_ff;
  logic [7:0]  nxt_sh;
  logic [7:0]  ptr_ff;
  logic [7:0]  nxt_ptr;
  logic        rw_ff;
  logic        nxt_rw;
  logic        oe_ff;
  logic        nxt_oe;
  logic        scl_ff;
  logic        sda_ff;
  dirc_req_t   req_ff;
  dirc_req_t   nxt_req;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;

  // ****************************************************************
  // Bus line edges
  // ****************************************************************
  assign scl_rise = scl & ~scl_ff;
  assign scl_fall = ~scl & scl_ff;
  assign start_c  = scl & scl_ff & sda_ff & ~sda_in;
  assign stop_c   = scl & scl_ff & ~sda_ff & sda_in;

  // ****************************************************************
  // Transfer sequencer
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_sh    = sh_ff;
    nxt_ptr   = ptr_ff;
    nxt_rw    = rw_ff;
    nxt_oe    = oe_ff;
    nxt_req   = '{wr: 1'b0, addr: ptr_ff, wdata: sh_ff};
    if (stop_c) begin
      nxt_state = ST_IDLE;
      nxt_oe    = 1'b0;
    end else if (start_c) begin
      nxt_state = ST_ADDR;
      nxt_cnt   = 4'h0;
      nxt_oe    = 1'b0;
    end else begin
      case (state_ff)
        ST_ADDR, ST_PTR, ST_WR: begin
          if (scl_rise) begin
            nxt_sh  = {sh_ff[6:0], sda_in};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == 4'h8) begin
            nxt_oe  = 1'b1;
            nxt_cnt = 4'h0;
            if (state_ff == ST_ADDR) begin
              // Only our own address is acknowledged
              if (sh_ff[7:1] == slave_addr) begin
                nxt_rw    = sh_ff[0];
                nxt_state = ST_ACK_A;
              end else begin
                nxt_oe    = 1'b0;
                nxt_state = ST_IDLE;
              end
            end else if (state_ff == ST_PTR) begin
              nxt_ptr   = sh_ff;
              nxt_state = ST_ACK_D;
            end else begin
              nxt_req   = '{wr: 1'b1, addr: ptr_ff, wdata: sh_ff};
              nxt_ptr   = ptr_ff + 8'h01;
              nxt_state = ST_ACK_D;
            end
          end
        end
        ST_ACK_A: begin
          if (scl_fall) begin
            nxt_cnt = 4'h0;
            if (rw_ff) begin
              nxt_sh    = rd_data;
              nxt_oe    = ~rd_data[7];
              nxt_state = ST_RD;
            end else begin
              nxt_oe    = 1'b0;
              nxt_state = ST_PTR;
            end
          end
        end
        ST_ACK_D: begin
          if (scl_fall) begin
            nxt_oe    = 1'b0;
            nxt_state = ST_WR;
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == 4'h7) begin
              nxt_oe    = 1'b0;
              nxt_ptr   = ptr_ff + 8'h01;
              nxt_state = ST_MACK;
            end else begin
              nxt_sh = {sh_ff[6:0], 1'b0};
              nxt_oe = ~sh_ff[6];
            end
          end
        end
        ST_MACK: begin
          // A not-acknowledge from the master ends the read burst
          if (scl_rise && sda_in) begin
            nxt_state = ST_IDLE;
          end else if (scl_rise) begin
            nxt_state = ST_ACK_A;
          end
        end
        default: begin
          nxt_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 4'h0;
      sh_ff    <= 8'h00;
      ptr_ff   <= 8'h00;
      rw_ff    <= 1'b0;
      oe_ff    <= 1'b0;
      scl_ff   <= 1'b1;
      sda_ff   <= 1'b1;
      req_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      sh_ff    <= nxt_sh;
      ptr_ff   <= nxt_ptr;
      rw_ff    <= nxt_rw;
      oe_ff    <= nxt_oe;
      scl_ff   <= scl;
      sda_ff   <= sda_in;
      req_ff   <= nxt_req;
    end
  end

  // Open-drain: the line is only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe  = oe_ff;
  assign rd_addr = ptr_ff;
  assign req     = req_ff;

endmodule // dirc_i2c_slave

/* File: dirc_regbank.sv */
// Address select, soft resets and output state control register bank
`timescale 1ns/1ps
// How it works
// RULE1 - address field 7:1 loads from strap
// RULE2 - bit 0 picks strap or programmed address
// RULE3 - full reset clears all, bit self-clears
// RULE4 - full reset reloads captured strap values
// RULE5 - core reset keeps registers, self-clears
// RULE6 - host waits half millisecond after core reset; the bench waits SETTLE, 250 clock cycles (1000 ns)
// RULE7 - output enable is one without override
// RULE8 - host issues core reset after enabling
// RULE9 - override bit gates register output values
// RULE10 - fallback clock emitted while lock lost
// RULE11 - sleep state select is one without override
// RULE12 - host writes reserved bits with reset values
module dirc_regbank import dirc_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl,
  input  wire logic       sda_in,
  input  wire logic [6:0] address_strap_pin,
  input  wire logic       link_lock,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            core_rst_out,
  output logic            out_drive_en,
  output logic            out_hold_low,
  output logic            fallback_clk_sel
);

  logic [7:0] addr_sel_ff;
  logic [7:0] nxt_addr_sel;
  logic [7:0] rst_ctl_ff;
  logic [7:0] nxt_rst_ctl;
  logic [7:0] out_cfg_ff;
  logic [7:0] nxt_out_cfg;
  logic [6:0] strap_ff;
  logic [6:0] nxt_strap;
  logic       strap_done_ff;
  logic [4:0] core_cnt_ff;
  logic [4:0] nxt_core_cnt;
  logic       core_rst_ff;
  logic       nxt_core_rst;
  logic       drive_ff;
  logic       nxt_drive;
  logic       hold_ff;
  logic       nxt_hold;
  logic       osc_sel_ff;
  logic       nxt_osc_sel;
  logic [6:0] slave_addr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  dirc_req_t  req;
  logic       oe_eff;
  logic       sleep_eff;

  function automatic logic ovr_pick(input logic ovr, input logic val);
    return ovr ? val : 1'b1;
  endfunction

  // ****************************************************************
  // Control bus
  // ****************************************************************
  dirc_i2c_slave u_slave (
    .clk        (clk),
    .rst        (rst),
    .scl        (scl),
    .sda_in     (sda_in),
    .slave_addr (slave_addr),
    .rd_data    (rd_data),
    .sda_out    (sda_out),
    .sda_oe     (sda_oe),
    .rd_addr    (rd_addr),
    .req        (req)
  );

  assign slave_addr = addr_sel_ff[ADDR_SRC_BIT] ?
                      addr_sel_ff[ADDR_MSB:ADDR_LSB] : strap_ff; // RULE2

  always_comb begin
    case (rd_addr)
      OFS_ADDR_SEL: rd_data = addr_sel_ff;
      OFS_RST_CTL:  rd_data = rst_ctl_ff;
      OFS_OUT_CFG:  rd_data = out_cfg_ff;
      default:      rd_data = RD_UNMAPPED;
    endcase
  end

  // ****************************************************************
  // Registers and soft resets
  // ****************************************************************
  always_comb begin
    nxt_addr_sel = addr_sel_ff;
    nxt_rst_ctl  = rst_ctl_ff;
    nxt_out_cfg  = out_cfg_ff;
    nxt_strap    = strap_ff;
    nxt_core_cnt = core_cnt_ff;
    nxt_core_rst = core_rst_ff;
    if (!strap_done_ff) begin
      // Strap is caught on the first edge after reset release
      nxt_strap    = address_strap_pin;
      nxt_addr_sel = {address_strap_pin, ADDR_SRC_RST}; // RULE1
    end else if (rst_ctl_ff[FULL_RST_BIT]) begin
      nxt_addr_sel = {strap_ff, ADDR_SRC_RST}; // RULE4
      nxt_rst_ctl  = RST_CTL_RST; // RULE3
      nxt_out_cfg  = OUT_CFG_RST; // RULE3
    end else begin
      if (req.wr) begin
        case (req.addr)
          OFS_ADDR_SEL: nxt_addr_sel = req.wdata;
          OFS_RST_CTL:  nxt_rst_ctl  = req.wdata;
          OFS_OUT_CFG:  nxt_out_cfg  = req.wdata;
          default:      nxt_rst_ctl  = rst_ctl_ff;
        endcase
      end
      // Registers stay put; only the core is reset
      if (rst_ctl_ff[CORE_RST_BIT]) begin
        nxt_rst_ctl[CORE_RST_BIT] = 1'b0; // RULE5
      end
    end
    // Both resets pulse the core for a fixed time
    if (rst_ctl_ff[CORE_RST_BIT] || rst_ctl_ff[FULL_RST_BIT]) begin
      nxt_core_cnt = CORE_RST_CYC; // RULE5
      nxt_core_rst = 1'b1;
    end else if (core_cnt_ff != 5'h00) begin
      nxt_core_cnt = core_cnt_ff - 5'h01;
      nxt_core_rst = (core_cnt_ff != 5'h01);
    end else begin
      nxt_core_rst = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_sel_ff   <= 8'h00;
      rst_ctl_ff    <= RST_CTL_RST;
      out_cfg_ff    <= OUT_CFG_RST;
      strap_ff      <= 7'h00;
      strap_done_ff <= 1'b0;
      core_cnt_ff   <= 5'h00;
      core_rst_ff   <= 1'b0;
    end else begin
      addr_sel_ff   <= nxt_addr_sel;
      rst_ctl_ff    <= nxt_rst_ctl;
      out_cfg_ff    <= nxt_out_cfg;
      strap_ff      <= nxt_strap;
      strap_done_ff <= 1'b1;
      core_cnt_ff   <= nxt_core_cnt;
      core_rst_ff   <= nxt_core_rst;
    end
  end

  // ****************************************************************
  // Output state control
  // ****************************************************************
  assign oe_eff  = ovr_pick(out_cfg_ff[OE_OVR_BIT],
                            out_cfg_ff[OE_VAL_BIT]); // RULE7 RULE9
  assign sleep_eff = ovr_pick(out_cfg_ff[OE_OVR_BIT],
                              out_cfg_ff[SLEEP_SEL_BIT]); // RULE11 RULE9

  always_comb begin
    // Drive and hold outputs are released while the core sits in reset; fallback select is not
    nxt_drive   = ~core_rst_ff & oe_eff & (link_lock | sleep_eff); // RULE11
    nxt_hold    = ~core_rst_ff & ~link_lock & sleep_eff; // RULE11
    nxt_osc_sel = out_cfg_ff[OSC_EMIT_BIT] & ~link_lock; // RULE10
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive_ff   <= 1'b0;
      hold_ff    <= 1'b0;
      osc_sel_ff <= 1'b0;
    end else begin
      drive_ff   <= nxt_drive;
      hold_ff    <= nxt_hold;
      osc_sel_ff <= nxt_osc_sel;
    end
  end

  assign core_rst_out     = core_rst_ff;
  assign out_drive_en     = drive_ff;
  assign out_hold_low     = hold_ff;
  assign fallback_clk_sel = osc_sel_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_addr_source: assert property ( // RULE2
    slave_addr == (addr_sel_ff[0] ? addr_sel_ff[7:1] : strap_ff))
    else $error("slave address source wrong");
  chk_strap_load: assert property ( // RULE1
    $rose(strap_done_ff) |-> addr_sel_ff == {strap_ff, 1'b0})
    else $error("strap address not loaded");
  chk_full_reload: assert property ( // RULE3
    strap_done_ff && rst_ctl_ff[1] |=> rst_ctl_ff == 8'h04 &&
    out_cfg_ff == 8'h80)
    else $error("full reset did not restore defaults");
  chk_strap_reload: assert property ( // RULE4
    strap_done_ff && rst_ctl_ff[1] |=> addr_sel_ff == {strap_ff, 1'b0})
    else $error("full reset did not reload strap");
  chk_strap_kept: assert property ( // RULE4
    strap_done_ff |=> $stable(strap_ff))
    else $error("captured strap value changed");
  chk_keep_regs: assert property ( // RULE5
    strap_done_ff && rst_ctl_ff[0] && !rst_ctl_ff[1] && !req.wr |=>
    $stable(out_cfg_ff) && $stable(addr_sel_ff) && !rst_ctl_ff[0])
    else $error("core reset disturbed registers");
  chk_core_pulse: assert property ( // RULE5
    rst_ctl_ff[0] |=> core_rst_ff [*8])
    else $error("core reset pulse too short");
  chk_oe_default: assert property ( // RULE7
    !out_cfg_ff[6] && !core_rst_ff |=> drive_ff)
    else $error("outputs not enabled without override");
  chk_ovr_value: assert property ( // RULE9
    out_cfg_ff[6] && !core_rst_ff |=>
    drive_ff == $past(out_cfg_ff[7] & (link_lock | out_cfg_ff[4])))
    else $error("override values not applied");
  chk_osc_fallback: assert property ( // RULE10
    1'b1 |=> osc_sel_ff == $past(out_cfg_ff[5] & ~link_lock))
    else $error("fallback clock select wrong");
  chk_sleep_default: assert property ( // RULE11
    !out_cfg_ff[6] && !link_lock && !core_rst_ff |=> hold_ff)
    else $error("sleep state not one without override");

  cov_full_reset: cover property (rst_ctl_ff[1] ##1 core_rst_ff);
  cov_core_reset: cover property ($fell(core_rst_ff));
  cov_ovr_unlock: cover property (out_cfg_ff[6] && !link_lock);
  cov_fallback:   cover property ($rose(osc_sel_ff));

endmodule // dirc_regbank

/* File: dirc_host.sv */
// Control-bus master model standing in for the host processor
`timescale 1ns/1ps
module dirc_host (
  input  wire logic clk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic m_low;

  // Open drain with pull-up: a released line reads high
  assign sda = ~(m_low | sda_oe);

  initial begin
    scl   = 1'b1;
    m_low = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Data moves only while the clock is low, well clear of its edges
  task automatic put(input logic b, output logic r);
    m_low <= ~b;
    step(4);
    scl <= 1'b1;
    step(4);
    r = sda;
    scl <= 1'b0;
    step(3);
  endtask

  task automatic start();
    m_low <= 1'b0;
    step(4);
    scl <= 1'b1;
    step(4);
    m_low <= 1'b1;
    step(4);
    scl <= 1'b0;
    step(3);
  endtask

  task automatic stop();
    m_low <= 1'b1;
    step(4);
    scl <= 1'b1;
    step(4);
    m_low <= 1'b0;
    step(4);
  endtask

  task automatic xfer(input logic [7:0] d, input logic mb,
                      output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--) put(d[i], q[i]);
    put(mb, r);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] o,
                    input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       r;
    start();
    xfer({a, 1'b0}, 1'b1, q, r);
    ok = ~r;
    if (ok) begin
      xfer(o, 1'b1, q, r);
      xfer(d, 1'b1, q, r);
    end
    stop();
  endtask

  // Single-byte read; the final not-acknowledge ends the transfer
  task automatic rd(input logic [6:0] a, input logic [7:0] o,
                    output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       r;
    start();
    xfer({a, 1'b0}, 1'b1, q, r);
    ok = ~r;
    if (ok) begin
      xfer(o, 1'b1, q, r);
      start();
      xfer({a, 1'b1}, 1'b1, q, r);
      xfer(8'hFF, 1'b1, d, r);
    end
    stop();
  endtask
endmodule // dirc_host

/* File: test_dirc_regbank.sv */
// Self-checking bench for the dirc register bank
`timescale 1ns/1ps
module test_dirc_regbank;
  import dirc_pkg::*;
  localparam logic [6:0] STRAP  = 7'h2C;
  localparam logic [6:0] PROG   = 7'h33;
  localparam logic [6:0] STRAP2 = 7'h15;
  // Host settle time, shortened to keep the run brief
  localparam int         SETTLE = 250;

  typedef struct packed {
    logic [7:0] cfg;
    logic       lock;
    logic [2:0] pins;
  } dirc_row_t;

  logic       clk;
  logic       rst;
  logic       scl;
  logic       sda;
  logic [6:0] strap;
  logic       link_lock;
  logic       sda_oe;
  logic       core_rst_out;
  logic       out_drive_en;
  logic       out_hold_low;
  logic       fallback_clk_sel;
  logic [3:0] pins;
  logic [7:0] prev;
  int         rst_len = 0;
  int         rst_base;
  int         n_fail;
  int         n_checks;

  // Pins: drive_en, hold_low, fallback for a given config and lock
  dirc_row_t rows [10] = '{
    '{8'h80, 1'b1, 3'b100}, '{8'h80, 1'b0, 3'b110},
    '{8'hA0, 1'b0, 3'b111}, '{8'hA0, 1'b1, 3'b100},
    '{8'h40, 1'b1, 3'b000}, '{8'hC0, 1'b0, 3'b000},
    '{8'hD0, 1'b0, 3'b110}, '{8'h50, 1'b1, 3'b000},
    '{8'hE0, 1'b1, 3'b100}, '{8'h60, 1'b0, 3'b001}};

  assign pins = {core_rst_out, out_drive_en, out_hold_low, fallback_clk_sel};

  dirc_regbank dirc_regbank_i (
    .clk              (clk),
    .rst              (rst),
    .scl              (scl),
    .sda_in           (sda),
    .address_strap_pin(strap),
    .link_lock        (link_lock),
    .sda_out          (),
    .sda_oe           (sda_oe),
    .core_rst_out     (core_rst_out),
    .out_drive_en     (out_drive_en),
    .out_hold_low     (out_hold_low),
    .fallback_clk_sel (fallback_clk_sel)
  );

  dirc_host dirc_host_i (
    .clk   (clk),
    .sda_oe(sda_oe),
    .scl   (scl),
    .sda   (sda)
  );

  initial clk = 1'b0;
  always #2 clk = ~clk;

  always @(posedge clk) begin
    if (core_rst_out === 1'b1) begin
      rst_len <= rst_len + 1;
    end
  end

  // ****************************************************************
  // Compare and access tasks
  // ****************************************************************
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_pin(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: pins %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic put_reg(input logic [6:0] a, input logic [7:0] o,
                         input logic [7:0] d, input logic exp_ok);
    logic ok;
    dirc_host_i.wr(a, o, d, ok);
    cmp_pin({3'h0, ok}, {3'h0, exp_ok});
  endtask

  task automatic chk_reg(input logic [6:0] a, input logic [7:0] o,
                         input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    dirc_host_i.rd(a, o, d, ok);
    cmp_reg(d, exp);
  endtask

  task automatic results();
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    results();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    n_fail    = 0;
    n_checks  = 0;
    rst       = 1'b1;
    strap     = STRAP;
    link_lock = 1'b1;
    prev      = OUT_CFG_RST;
    repeat (12) @(posedge clk);
    @(negedge clk);
    cmp_pin(pins, 4'h0);
    @(posedge clk);
    rst <= 1'b0;
    chk_reg(STRAP, OFS_ADDR_SEL, {STRAP, 1'b0});
    chk_reg(STRAP, OFS_RST_CTL, RST_CTL_RST);
    chk_reg(STRAP, OFS_OUT_CFG, OUT_CFG_RST);
    foreach (rows[i]) begin
      @(posedge clk);
      link_lock <= rows[i].lock;
      put_reg(STRAP, OFS_OUT_CFG, rows[i].cfg, 1'b1);
      if (rows[i].cfg[OE_VAL_BIT] && !prev[OE_VAL_BIT]) begin
        @(posedge clk);
        rst_base = rst_len;
        put_reg(STRAP, OFS_RST_CTL, 8'h05, 1'b1);
        repeat (SETTLE) @(posedge clk);
        cmp_reg(8'(rst_len - rst_base), {3'h0, CORE_RST_CYC});
        chk_reg(STRAP, OFS_RST_CTL, RST_CTL_RST);
      end
      prev = rows[i].cfg;
      chk_reg(STRAP, OFS_OUT_CFG, rows[i].cfg);
      @(negedge clk);
      cmp_pin(pins, {1'b0, rows[i].pins});
    end
    put_reg(STRAP, OFS_ADDR_SEL, {PROG, 1'b1}, 1'b1);
    put_reg(STRAP, OFS_OUT_CFG, 8'hE0, 1'b0);
    chk_reg(PROG, OFS_ADDR_SEL, {PROG, 1'b1});
    @(posedge clk);
    strap <= STRAP2;
    put_reg(PROG, 8'h07, 8'h5A, 1'b1);
    chk_reg(PROG, 8'h07, RD_UNMAPPED);
    put_reg(PROG, OFS_OUT_CFG, 8'hE0, 1'b1);
    put_reg(PROG, OFS_RST_CTL, 8'h06, 1'b1);
    repeat (SETTLE) @(posedge clk);
    put_reg(PROG, OFS_OUT_CFG, 8'hE0, 1'b0);
    chk_reg(STRAP, OFS_ADDR_SEL, {STRAP, 1'b0});
    chk_reg(STRAP, OFS_RST_CTL, RST_CTL_RST);
    chk_reg(STRAP, OFS_OUT_CFG, OUT_CFG_RST);
    // Second hardware reset, unlocked, with a new strap on the pin
    @(posedge clk);
    link_lock <= 1'b0;
    rst       <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    cmp_pin(pins, 4'h0);
    @(posedge clk);
    rst <= 1'b0;
    chk_reg(STRAP2, OFS_ADDR_SEL, {STRAP2, 1'b0});
    @(negedge clk);
    cmp_pin(pins, 4'b0110);
    results();
  end
endmodule // test_dirc_regbank
